// ### core/sfr_bank0.sv
// Bank 0 special register map: storage, read mux, reset values and event flags
//
// What this block does
// - Every unimplemented address or bit in the bank reads back as zero, except reserved bit 1 of the first converter control register.
// - Power-on reset loads the processor state with 0001 1000, other resets clear its top three bits, load the cause bits and keep the arithmetic flags.
// - Any reset zeroes timer2 count and control, serial control, capture control, port four latch and the program counter high buffer.
// - Without the converter, its result and control registers do not exist and read as zero.
// - With the converter, port one reads --0x 0000 after reset, its analog-capable pins as zero.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0 import sfr_pkg::*; #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic cause_timeout,
  input wire logic cause_powerdown,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [DATA_W-1:0] rdata,
  // Core side
  input wire logic arith_we,
  input wire logic [2:0] arith_flags,
  input wire logic [DATA_W-1:0] indirect_rdata,
  output logic indirect_we,
  output logic [DATA_W-1:0] indirect_wdata,
  output logic [DATA_W-1:0] indirect_pointer,
  output logic [DATA_W-1:0] program_counter_low,
  output logic [4:0] program_counter_high_buffer,
  output logic [DATA_W-1:0] processor_state,
  // Peripheral events
  input wire logic [2:0] core_int_event,
  input wire logic [7:0] periph_int_event,
  input wire logic conv_result_we,
  input wire logic [DATA_W-1:0] conv_result_in,
  // Pins
  input wire logic [5:0] port_one_pins,
  input wire logic [7:0] port_two_pins,
  input wire logic [5:0] port_three_pins,
  input wire logic [7:0] port_four_pins,
  input wire logic [7:0] port_five_pins,
  output logic [5:0] port_one_latch,
  output logic [7:0] port_two_latch,
  output logic [5:0] port_three_latch,
  output logic [7:0] port_four_latch,
  // Control registers seen by the peripherals
  output logic [DATA_W-1:0] core_interrupt_control,
  output logic [DATA_W-1:0] peripheral_interrupt_flags,
  output logic [DATA_W-1:0] timer1_control,
  output logic [DATA_W-1:0] timer2_control,
  output logic [DATA_W-1:0] serial_port_control,
  output logic [DATA_W-1:0] capture_compare_control,
  output logic [DATA_W-1:0] converter_control_first
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer0_count;
    logic [7:0] pc_low;
    logic [7:0] ind_pointer;
    logic [7:0] port_one;
    logic [7:0] port_two;
    logic [7:0] port_three;
    logic [7:0] port_four;
    logic [7:0] pc_high_buf;
    logic [7:0] core_int;
    logic [7:0] periph_flags;
    logic [7:0] timer1_low;
    logic [7:0] timer1_high;
    logic [7:0] timer1_ctrl;
    logic [7:0] timer2_count;
    logic [7:0] timer2_ctrl;
    logic [7:0] serial_buf;
    logic [7:0] serial_ctrl;
    logic [7:0] capcmp_low;
    logic [7:0] capcmp_high;
    logic [7:0] capcmp_ctrl;
    logic [7:0] conv_result;
    logic [7:0] conv_ctrl;
    logic ind_we;
    logic [7:0] ind_wdata;
    logic [7:0] rdata;
  } sfr_bank_t;

  sfr_bank_t s_q;
  sfr_bank_t s_d;

  // ----------------------------------------------------------------
  // Pin synchroniser and processor state
  // ----------------------------------------------------------------
  logic [35:0] pins_sync;
  sfr_state_if st_if ();

  sfr_sync #(
    .WIDTH(36)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in({port_one_pins, port_two_pins, port_three_pins, port_four_pins, port_five_pins}),
    .sync_out(pins_sync)
  );

  sfr_state_reg u_state (
    .clk(clk),
    .rst(rst),
    .st(st_if.owner)
  );

  assign st_if.por = por;
  assign st_if.sw_we = we && (addr == A_PROCESSOR_STATE);
  assign st_if.sw_wdata = wdata;
  assign st_if.arith_we = arith_we;
  assign st_if.arith_flags = arith_flags;
  assign st_if.cause_timeout = cause_timeout;
  assign st_if.cause_powerdown = cause_powerdown;

  // ----------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------
  logic [7:0] pin_one_view;
  logic [7:0] conv_mask;
  logic [7:0] read_value;

  // Analog-capable pins always read low when the converter is present; no setting makes them digital
  assign pin_one_view = {2'b00, pins_sync[35:30]} & M_PORT_ONE &
                        (HAS_CONVERTER ? ~M_PORT_ONE_ANALOG : M_FULL);
  assign conv_mask = HAS_CONVERTER ? M_FULL : ~M_CONV_FLAG;

  always_comb begin
    unique case (addr)
      A_INDIRECT_WINDOW: read_value = indirect_rdata;
      A_TIMER0_COUNT: read_value = s_q.timer0_count;
      A_PC_LOW: read_value = s_q.pc_low;
      A_PROCESSOR_STATE: read_value = st_if.value;
      A_INDIRECT_POINTER: read_value = s_q.ind_pointer;
      A_PORT_ONE: read_value = pin_one_view;
      A_PORT_TWO: read_value = pins_sync[29:22];
      A_PORT_THREE: read_value = {2'b00, pins_sync[21:16]};
      A_PORT_FOUR: read_value = pins_sync[15:8];
      A_PORT_FIVE: read_value = pins_sync[7:0];
      A_PC_HIGH_BUFFER: read_value = s_q.pc_high_buf & M_PC_HIGH;
      A_CORE_INT_CTRL: read_value = s_q.core_int;
      A_PERIPH_INT_FLAGS: read_value = s_q.periph_flags & M_PERIPH_FLAGS & conv_mask;
      A_TIMER1_LOW: read_value = s_q.timer1_low;
      A_TIMER1_HIGH: read_value = s_q.timer1_high;
      A_TIMER1_CTRL: read_value = s_q.timer1_ctrl & M_TIMER1_CTRL;
      A_TIMER2_COUNT: read_value = s_q.timer2_count;
      A_TIMER2_CTRL: read_value = s_q.timer2_ctrl & M_TIMER2_CTRL;
      A_SERIAL_BUFFER: read_value = s_q.serial_buf;
      A_SERIAL_CTRL: read_value = s_q.serial_ctrl;
      A_CAPCMP_LOW: read_value = s_q.capcmp_low;
      A_CAPCMP_HIGH: read_value = s_q.capcmp_high;
      A_CAPCMP_CTRL: read_value = s_q.capcmp_ctrl & M_CAPCMP_CTRL;
      A_CONV_RESULT: read_value = HAS_CONVERTER ? s_q.conv_result : RST_ZERO;
      A_CONV_CTRL_FIRST: read_value = HAS_CONVERTER ? s_q.conv_ctrl : RST_ZERO;
      default: read_value = RST_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ind_we = 1'b0;
    // Read data stand for exactly the cycle after the strobe
    s_d.rdata = re ? read_value : RST_ZERO;
    if (we) begin
      unique case (addr)
        A_INDIRECT_WINDOW: begin
          s_d.ind_we = 1'b1;
          s_d.ind_wdata = wdata;
        end
        A_TIMER0_COUNT: s_d.timer0_count = wdata;
        A_PC_LOW: s_d.pc_low = wdata;
        A_INDIRECT_POINTER: s_d.ind_pointer = wdata;
        A_PORT_ONE: s_d.port_one = wdata & M_PORT_ONE;
        A_PORT_TWO: s_d.port_two = wdata;
        A_PORT_THREE: s_d.port_three = wdata & M_PORT_THREE;
        A_PORT_FOUR: s_d.port_four = wdata;
        A_PC_HIGH_BUFFER: s_d.pc_high_buf = wdata & M_PC_HIGH;
        A_CORE_INT_CTRL: s_d.core_int = wdata;
        A_PERIPH_INT_FLAGS: s_d.periph_flags = wdata & M_PERIPH_FLAGS & conv_mask;
        A_TIMER1_LOW: s_d.timer1_low = wdata;
        A_TIMER1_HIGH: s_d.timer1_high = wdata;
        A_TIMER1_CTRL: s_d.timer1_ctrl = wdata & M_TIMER1_CTRL;
        A_TIMER2_COUNT: s_d.timer2_count = wdata;
        A_TIMER2_CTRL: s_d.timer2_ctrl = wdata & M_TIMER2_CTRL;
        A_SERIAL_BUFFER: s_d.serial_buf = wdata;
        A_SERIAL_CTRL: s_d.serial_ctrl = wdata;
        A_CAPCMP_LOW: s_d.capcmp_low = wdata;
        A_CAPCMP_HIGH: s_d.capcmp_high = wdata;
        A_CAPCMP_CTRL: s_d.capcmp_ctrl = wdata & M_CAPCMP_CTRL;
        // Reserved bit 1 is stored as written; firmware keeps it clear
        A_CONV_CTRL_FIRST: s_d.conv_ctrl = HAS_CONVERTER ? wdata : RST_ZERO;
        default: s_d.rdata = s_d.rdata;
      endcase
    end
    // Hardware events win over a software clear in the same cycle
    s_d.core_int = s_d.core_int | ({5'b00000, core_int_event} & M_INT_FLAGS);
    s_d.periph_flags = s_d.periph_flags | (periph_int_event & M_PERIPH_FLAGS & conv_mask);
    if (conv_result_we && HAS_CONVERTER) begin
      s_d.conv_result = conv_result_in;
    end
    if (rst) begin
      if (por) begin
        // Unknown power-on values are settled at zero for determinism
        s_d = '0;
      end
      s_d.ind_we = 1'b0;
      s_d.rdata = RST_ZERO;
      s_d.pc_low = RST_ZERO;
      s_d.timer2_count = RST_ZERO;
      s_d.timer2_ctrl = RST_ZERO;
      s_d.serial_ctrl = RST_ZERO;
      s_d.capcmp_ctrl = RST_ZERO;
      s_d.port_four = RST_ZERO;
      s_d.pc_high_buf = RST_ZERO;
      s_d.core_int = s_q.core_int & M_INT_KEEP & {8{~por}};
      s_d.periph_flags = RST_ZERO;
      s_d.conv_ctrl = RST_ZERO;
      // Port one analog pins come up analog so they read zero
      // Without the converter there are no analog pins, so a warm reset keeps the latch whole
      s_d.port_one = s_q.port_one & {8{~por}} &
                     (HAS_CONVERTER ? ~M_PORT_ONE_ANALOG : M_FULL);
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = s_q.rdata;
  assign indirect_we = s_q.ind_we;
  assign indirect_wdata = s_q.ind_wdata;
  assign indirect_pointer = s_q.ind_pointer;
  assign program_counter_low = s_q.pc_low;
  assign program_counter_high_buffer = s_q.pc_high_buf[4:0];
  assign processor_state = st_if.value;
  assign port_one_latch = s_q.port_one[5:0];
  assign port_two_latch = s_q.port_two;
  assign port_three_latch = s_q.port_three[5:0];
  assign port_four_latch = s_q.port_four;
  assign core_interrupt_control = s_q.core_int;
  assign peripheral_interrupt_flags = s_q.periph_flags & M_PERIPH_FLAGS & conv_mask;
  assign timer1_control = s_q.timer1_ctrl;
  assign timer2_control = s_q.timer2_ctrl;
  assign serial_port_control = s_q.serial_ctrl;
  assign capture_compare_control = s_q.capcmp_ctrl;
  assign converter_control_first = s_q.conv_ctrl;

endmodule : sfr_bank0
`default_nettype wire

// ### core/sfr_pkg.sv
// Package: addresses, field layouts, masks and reset values of the bank 0 register map
package sfr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] A_INDIRECT_WINDOW = 7'h00;
  localparam logic [6:0] A_TIMER0_COUNT = 7'h01;
  localparam logic [6:0] A_PC_LOW = 7'h02;
  localparam logic [6:0] A_PROCESSOR_STATE = 7'h03;
  localparam logic [6:0] A_INDIRECT_POINTER = 7'h04;
  localparam logic [6:0] A_PORT_ONE = 7'h05;
  localparam logic [6:0] A_PORT_TWO = 7'h06;
  localparam logic [6:0] A_PORT_THREE = 7'h07;
  localparam logic [6:0] A_PORT_FOUR = 7'h08;
  localparam logic [6:0] A_PORT_FIVE = 7'h09;
  localparam logic [6:0] A_PC_HIGH_BUFFER = 7'h0A;
  localparam logic [6:0] A_CORE_INT_CTRL = 7'h0B;
  localparam logic [6:0] A_PERIPH_INT_FLAGS = 7'h0C;
  localparam logic [6:0] A_TIMER1_LOW = 7'h0E;
  localparam logic [6:0] A_TIMER1_HIGH = 7'h0F;
  localparam logic [6:0] A_TIMER1_CTRL = 7'h10;
  localparam logic [6:0] A_TIMER2_COUNT = 7'h11;
  localparam logic [6:0] A_TIMER2_CTRL = 7'h12;
  localparam logic [6:0] A_SERIAL_BUFFER = 7'h13;
  localparam logic [6:0] A_SERIAL_CTRL = 7'h14;
  localparam logic [6:0] A_CAPCMP_LOW = 7'h15;
  localparam logic [6:0] A_CAPCMP_HIGH = 7'h16;
  localparam logic [6:0] A_CAPCMP_CTRL = 7'h17;
  localparam logic [6:0] A_CONV_RESULT = 7'h1E;
  localparam logic [6:0] A_CONV_CTRL_FIRST = 7'h1F;

  // ----------------------------------------------------------------
  // Implemented bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] M_FULL = 8'hFF;
  localparam logic [7:0] M_PORT_ONE = 8'h3F;
  localparam logic [7:0] M_PORT_THREE = 8'h3F;
  localparam logic [7:0] M_PC_HIGH = 8'h1F;
  localparam logic [7:0] M_PERIPH_FLAGS = 8'hCF;
  localparam logic [7:0] M_CONV_FLAG = 8'h40;
  localparam logic [7:0] M_TIMER1_CTRL = 8'h3F;
  localparam logic [7:0] M_TIMER2_CTRL = 8'h7F;
  localparam logic [7:0] M_CAPCMP_CTRL = 8'h3F;
  localparam logic [7:0] M_PORT_ONE_ANALOG = 8'h2F;
  localparam logic [7:0] M_INT_FLAGS = 8'h07;
  localparam logic [7:0] M_INT_KEEP = 8'h01;

  // ----------------------------------------------------------------
  // Processor state fields and reset values
  // ----------------------------------------------------------------
  localparam int PS_TIMEOUT = 4;
  localparam int PS_POWERDOWN = 3;
  localparam logic [7:0] PS_WR_MASK = 8'hE7;
  localparam logic [7:0] PS_ARITH_MASK = 8'h07;
  localparam logic [7:0] PS_POR_VALUE = 8'h18;
  localparam logic [7:0] RST_ZERO = 8'h00;

endpackage : sfr_pkg

// ### core/sfr_state_if.sv
// Interface: link between the register bank and its processor state register
`timescale 1ns/1ps
`default_nettype none
interface sfr_state_if;
  logic por;
  logic sw_we;
  logic [7:0] sw_wdata;
  logic arith_we;
  logic [2:0] arith_flags;
  logic cause_timeout;
  logic cause_powerdown;
  logic [7:0] value;

  modport owner (
    input por, sw_we, sw_wdata, arith_we, arith_flags, cause_timeout, cause_powerdown,
    output value
  );
  modport user (
    output por, sw_we, sw_wdata, arith_we, arith_flags, cause_timeout, cause_powerdown,
    input value
  );
endinterface : sfr_state_if
`default_nettype wire

// ### core/sfr_state_reg.sv
// Processor state register with power-on and other reset behaviour
`timescale 1ns/1ps
`default_nettype none
module sfr_state_reg import sfr_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bank side
  sfr_state_if.owner st
);

  typedef struct packed {
    logic [7:0] value;
  } sfr_state_t;

  sfr_state_t s_q;
  sfr_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (rst) begin
      if (st.por) begin
        s_d.value = PS_POR_VALUE;
      end else begin
        // Arithmetic flags survive; cause bits come from the reset source
        s_d.value = s_q.value & PS_ARITH_MASK;
        s_d.value[PS_TIMEOUT] = st.cause_timeout;
        s_d.value[PS_POWERDOWN] = st.cause_powerdown;
      end
    end else begin
      if (st.sw_we) begin
        s_d.value = (st.sw_wdata & PS_WR_MASK) | (s_q.value & ~PS_WR_MASK);
      end
      if (st.arith_we) begin
        s_d.value[2:0] = st.arith_flags;
      end
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign st.value = s_q.value;

endmodule : sfr_state_reg
`default_nettype wire

// ### core/sfr_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module sfr_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sfr_sync_t;

  sfr_sync_t s_q;
  sfr_sync_t s_d;

  // First stage feeds only the second one
  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
    if (rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign sync_out = s_q.stable;

endmodule : sfr_sync
`default_nettype wire

// ### dv/sfr_bank0_monitor.sv
// Checker for the bank 0 register map ports
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0_monitor import sfr_pkg::*; #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic cause_timeout,
  input wire logic cause_powerdown,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  input wire logic [DATA_W-1:0] rdata,
  // Outputs watched
  input wire logic indirect_we,
  input wire logic [DATA_W-1:0] indirect_wdata,
  input wire logic [4:0] program_counter_high_buffer,
  input wire logic [DATA_W-1:0] processor_state,
  input wire logic [7:0] port_four_latch,
  input wire logic [DATA_W-1:0] timer2_control,
  input wire logic [DATA_W-1:0] serial_port_control,
  input wire logic [DATA_W-1:0] capture_compare_control
);
  // --------
  // Properties
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_read_idle: assert property ($past(re) == 1'b0 |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (re && (addr == 7'h0D || addr inside {[7'h18:7'h1D]}
    || addr >= 7'h20) |=> rdata == 8'h00) else $error("unmapped read not zero");
  chk_no_converter: assert property (!HAS_CONVERTER && re && addr >= A_CONV_RESULT
    && addr <= A_CONV_CTRL_FIRST |=> rdata == 8'h00) else $error("converter read not zero");
  chk_por_state: assert property ($fell(rst) && $past(por)
    |-> processor_state == PS_POR_VALUE) else $error("power-on state wrong");
  chk_warm_state: assert property ($fell(rst) && !$past(por) |-> processor_state[7:3]
    == {3'b000, $past(cause_timeout), $past(cause_powerdown)}) else $error("warm state wrong");
  chk_reset_clears: assert property ($fell(rst) |-> ((timer2_control | serial_port_control
    | capture_compare_control | port_four_latch) == 8'h00 && program_counter_high_buffer
    == 5'h00)) else $error("reset did not clear");
  chk_t2_write: assert property (we && addr == A_TIMER2_CTRL
    |=> timer2_control == ($past(wdata) & M_TIMER2_CTRL)) else $error("timer2 write wrong");
  chk_pchigh_write: assert property (we && addr == A_PC_HIGH_BUFFER
    |=> program_counter_high_buffer == 5'($past(wdata))) else $error("pc high write wrong");
  chk_window_write: assert property (we && addr == A_INDIRECT_WINDOW
    |=> indirect_we && indirect_wdata == $past(wdata)) else $error("window write wrong");
  chk_port_analog: assert property (HAS_CONVERTER && re && addr == A_PORT_ONE
    |=> (rdata & 8'hEF) == 8'h00) else $error("analog pins not zero");

  cov_warm: cover property ($fell(rst) && !$past(por));
  cov_t2: cover property (we && addr == A_TIMER2_CTRL);
  cov_read: cover property (re ##1 rdata != 8'h00);
endmodule : sfr_bank0_monitor
`default_nettype wire

// ### dv/sfr_bank0_bench.sv
// Testbench for the bank 0 register map, both variants side by side
`timescale 1ns/1ps
`default_nettype none
module sfr_bank0_bench import sfr_pkg::*; ;
  // --------
  // Signals
  // --------
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, cause_timeout = 1'b0, cause_powerdown = 1'b0;
  logic we = 1'b0, re = 1'b0, arith_we = 1'b0, conv_result_we = 1'b0, indirect_we;
  logic [6:0] addr = 7'h00;
  logic [2:0] arith_flags = 3'h0, core_int_event = 3'h0;
  logic [7:0] wdata = 8'h00, indirect_rdata = 8'h00, periph_int_event = 8'h00;
  logic [7:0] conv_result_in = 8'h00, port_two_pins = 8'h00, port_four_pins = 8'h00;
  logic [7:0] port_five_pins = 8'h00, rdata, rdata2, indirect_wdata, indirect_pointer;
  logic [5:0] port_one_pins = 6'h00, port_three_pins = 6'h00, port_one_latch, port_three_latch;
  logic [4:0] program_counter_high_buffer;
  logic [7:0] program_counter_low, processor_state, port_two_latch, port_four_latch;
  logic [7:0] core_interrupt_control, peripheral_interrupt_flags, timer1_control;
  logic [7:0] timer2_control, serial_port_control, capture_compare_control;
  logic [7:0] converter_control_first;
  int fail_count = 0, checked = 0;
  logic [6:0] exp_rw_zero [6] = '{A_TIMER2_COUNT, A_TIMER2_CTRL, A_SERIAL_CTRL,
    A_CAPCMP_CTRL, A_PC_HIGH_BUFFER, A_PC_LOW};

  // Second copy lacks the converter; only its read data is observed
  sfr_bank0 #(.HAS_CONVERTER(1'b1)) sfr_bank0_i (.*);
  sfr_bank0 #(.HAS_CONVERTER(1'b0)) sfr_bank0_i2 (.rdata(rdata2), .indirect_we(),
    .indirect_wdata(), .indirect_pointer(), .program_counter_low(),
    .program_counter_high_buffer(), .processor_state(), .port_one_latch(),
    .port_two_latch(), .port_three_latch(), .port_four_latch(),
    .core_interrupt_control(), .peripheral_interrupt_flags(), .timer1_control(),
    .timer2_control(), .serial_port_control(), .capture_compare_control(),
    .converter_control_first(), .*);

  always #5 clk = ~clk;

  // --------
  // Tasks
  // --------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rdc(input logic [6:0] a, input logic [7:0] e1, input logic [7:0] e2);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    cmp(rdata, e1);
    cmp(rdata2, e2);
  endtask : rdc

  function automatic logic [7:0] exp_rw(input logic [6:0] a);
    case (a)
      A_TIMER0_COUNT, A_PC_LOW, A_PROCESSOR_STATE, A_INDIRECT_POINTER, A_CORE_INT_CTRL,
      A_TIMER1_LOW, A_TIMER1_HIGH, A_TIMER2_COUNT, A_SERIAL_BUFFER, A_SERIAL_CTRL,
      A_CAPCMP_LOW, A_CAPCMP_HIGH: return 8'hFF;
      A_PC_HIGH_BUFFER: return 8'h1F;
      A_PERIPH_INT_FLAGS: return 8'h8F;
      A_TIMER1_CTRL, A_CAPCMP_CTRL: return 8'h3F;
      A_TIMER2_CTRL: return 8'h7F;
      A_CONV_CTRL_FIRST: return 8'hFD;
      default: return 8'h00;
    endcase
  endfunction : exp_rw

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // --------
  // Sequence
  // --------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    for (int a = 0; a < 36; a++) begin
      rdc(7'(a), a == 3 ? 8'h18 : 8'h00, a == 3 ? 8'h18 : 8'h00);
    end
    rdc(7'h7F, 8'h00, 8'h00);
    $display("test power-on values done");
    // Converter flag kept clear for the plain variant, reserved bit 1 kept clear
    for (int a = 0; a < 32; a++) begin
      wr(7'(a), a == 12 ? 8'hBF : (a == 31 ? 8'hFD : 8'hFF));
      rdc(7'(a), exp_rw(7'(a)), a == 31 ? 8'h00 : exp_rw(7'(a)));
    end
    cmp({2'b00, port_one_latch}, 8'h3F);
    cmp(port_four_latch, 8'hFF);
    cmp(indirect_wdata, 8'hFF);
    cmp(indirect_pointer, 8'hFF);
    cmp(program_counter_low, 8'hFF);
    cmp({3'b000, program_counter_high_buffer}, 8'h1F);
    cmp(port_two_latch, 8'hFF);
    cmp({2'b00, port_three_latch}, 8'h3F);
    cmp(core_interrupt_control, 8'hFF);
    cmp(peripheral_interrupt_flags, 8'h8F);
    cmp(timer1_control, 8'h3F);
    cmp(timer2_control, 8'h7F);
    cmp(serial_port_control, 8'hFF);
    cmp(capture_compare_control, 8'h3F);
    cmp(converter_control_first, 8'hFD);
    $display("test write and read back done");
    @(posedge clk);
    port_one_pins <= 6'h3F;
    port_two_pins <= 8'hA5;
    port_three_pins <= 6'h2A;
    port_four_pins <= 8'hC3;
    port_five_pins <= 8'h5A;
    indirect_rdata <= 8'h3C;
    repeat (3) @(posedge clk);
    rdc(A_PORT_ONE, 8'h10, 8'h3F);
    rdc(A_PORT_TWO, 8'hA5, 8'hA5);
    rdc(A_PORT_THREE, 8'h2A, 8'h2A);
    rdc(A_PORT_FOUR, 8'hC3, 8'hC3);
    rdc(A_PORT_FIVE, 8'h5A, 8'h5A);
    rdc(A_INDIRECT_WINDOW, 8'h3C, 8'h3C);
    $display("test pins done");
    wr(A_PERIPH_INT_FLAGS, 8'h00);
    wr(A_CORE_INT_CTRL, 8'h00);
    @(posedge clk);
    periph_int_event <= 8'hFF;
    core_int_event <= 3'h7;
    conv_result_we <= 1'b1;
    conv_result_in <= 8'h96;
    @(posedge clk);
    periph_int_event <= 8'h00;
    core_int_event <= 3'h0;
    conv_result_we <= 1'b0;
    rdc(A_PERIPH_INT_FLAGS, 8'hCF, 8'h8F);
    rdc(A_CORE_INT_CTRL, 8'h07, 8'h07);
    rdc(A_CONV_RESULT, 8'h96, 8'h00);
    cmp(peripheral_interrupt_flags, 8'hCF);
    cmp(core_interrupt_control, 8'h07);
    $display("test events done");
    @(posedge clk);
    arith_we <= 1'b1;
    arith_flags <= 3'h5;
    @(posedge clk);
    arith_we <= 1'b0;
    cause_timeout <= 1'b1;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp(processor_state, 8'h15);
    cmp(port_four_latch, 8'h00);
    cmp({2'b00, port_one_latch}, 8'h10);
    cmp(timer1_control, 8'h3F);
    cmp(converter_control_first, 8'h00);
    cmp(peripheral_interrupt_flags, 8'h00);
    foreach (exp_rw_zero[i]) rdc(exp_rw_zero[i], 8'h00, 8'h00);
    rdc(A_PROCESSOR_STATE, 8'h15, 8'h15);
    rdc(A_TIMER0_COUNT, 8'hFF, 8'hFF);
    rdc(A_CORE_INT_CTRL, 8'h01, 8'h01);
    $display("test warm reset done");
    test_done();
  end

  // Hang guard
  initial begin
    #500_000;
    $display("[FAIL] %0t run timed out", $time);
    fail_count++;
    test_done();
  end
endmodule : sfr_bank0_bench

bind sfr_bank0 sfr_bank0_monitor #(.HAS_CONVERTER(HAS_CONVERTER)) sfr_bank0_monitor_i (.*);
`default_nettype wire
